/* core/pdw_ctrl.sv */
// power-down wake and clock recovery controller
`timescale 1ns/10ps
`default_nettype none
`include "pdw_params.svh"
module pdw_ctrl #(
    parameter int INIT_CYCLES = `PDW_INIT_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // external data bus register access
    input wire logic [15:0] xaddr,
    input wire logic xwr,
    input wire logic xrd,
    input wire logic [7:0] xwdata,
    output logic [7:0] xrdata,
    // processor power control
    input wire logic pd_request,
    input wire logic [7:0] pd_select,
    input wire logic ie_global,
    input wire logic ie_a,
    input wire logic ie_b,
    input wire logic level_a,
    input wire logic level_b,
    // wake sources, asynchronous pins and sidebands
    input wire logic ext_reset_pin_n,
    input wire logic app_reset_sideband,
    input wire logic ext_irq_sideband_a,
    input wire logic ext_irq_sideband_b,
    input wire logic supply_fail,
    input wire logic watchdog_reset,
    // status and controls to the rest of the chip
    output logic powerdown_flag,
    output logic clock_gate_en,
    output logic osc_enable,
    output logic crystal_select,
    output logic [7:0] memory_timing_ctrl,
    output logic cpu_reset,
    output logic cpu_resume,
    output logic [15:0] cpu_start_addr,
    output logic irq_handler_req,
    output logic init_busy
);
    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    // stage one is read by stage two only
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {watchdog_reset, supply_fail, ext_irq_sideband_b,
                      ext_irq_sideband_a, app_reset_sideband, ~ext_reset_pin_n};
            sync2 <= sync1;
        end
    end
    logic pin_rst;
    logic app_rst;
    logic irq_a;
    logic irq_b;
    logic por_rst;
    logic wdt_rst;
    assign pin_rst = sync2[0];
    assign app_rst = sync2[1];
    assign irq_a = sync2[2];
    assign irq_b = sync2[3];
    assign por_rst = sync2[4];
    assign wdt_rst = sync2[5];

    // qualified irq wake: enable, global enable, level mode
    logic irq_wake;
    assign irq_wake = ie_global & ((irq_a & ie_a & level_a) |
                                   (irq_b & ie_b & level_b));

    // -----------------------------------------------------------------
    // asynchronous flag clear
    // -----------------------------------------------------------------
    // the raw irq clears a latch with no clock, since clocks are stopped
    logic async_clr_n;
    assign async_clr_n = rst_n & ~(ie_global & ((ext_irq_sideband_a & ie_a & level_a) |
                         (ext_irq_sideband_b & ie_b & level_b)));
    // sequencer state and its decodes are declared here because the
    // flag latch below already reads them
    pdw_pkg::pdw_state_t state; // one-hot sequencer state
    logic state_is_run; // sequencer sits in normal run
    logic pd_exit; // any reset-type exit, synchronised
    logic [15:0] init_cnt; // cycles spent in full init
    // the latch sets on the processor's request and clears either on a
    // reset-type exit or, with no clock at all, on a qualified irq level
    logic pd_latch;
    always_ff @(posedge sys_clk or negedge async_clr_n) begin
        if (!async_clr_n) begin
            pd_latch <= 1'b0;
        end else begin
            pd_latch <= (pd_latch | (pd_request & state_is_run)) & ~pd_exit;
        end
    end
    // resynchronise the cleared latch before ungating clocks
    logic [1:0] pd_sync;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_sync <= 2'b00;
        end else begin
            pd_sync <= {pd_sync[0], pd_latch};
        end
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    // init counts up to the parameter, run waits for the request, down
    // waits for a wake, osc holds while the irq stands, wake is one cycle
    // a pin or supply reset overrides every state and restarts init
    assign state_is_run = (state == pdw_pkg::PDW_RUN);
    // reset-type exits; watchdog is ignored while down
    assign pd_exit = pin_rst | app_rst | por_rst;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pdw_pkg::PDW_INIT;
            init_cnt <= 16'h0000;
        end else if (pin_rst | por_rst) begin
            // whole system reset, full init on the ring oscillator
            state <= pdw_pkg::PDW_INIT;
            init_cnt <= 16'h0000;
        end else begin
            case (state)
                pdw_pkg::PDW_INIT: begin
                    if (init_cnt == 16'(INIT_CYCLES - 1)) begin
                        state <= pdw_pkg::PDW_RUN;
                    end
                    init_cnt <= init_cnt + 16'h0001;
                end
                pdw_pkg::PDW_RUN: begin
                    if (pd_request) begin
                        state <= pdw_pkg::PDW_DOWN;
                    end
                end
                pdw_pkg::PDW_DOWN: begin
                    if (app_rst) begin
                        state <= pdw_pkg::PDW_RUN;
                    end else if (irq_wake) begin
                        state <= pdw_pkg::PDW_OSC;
                    end
                end
                pdw_pkg::PDW_OSC: begin
                    // oscillator runs while irq held; exit on release
                    if (app_rst) begin
                        state <= pdw_pkg::PDW_RUN;
                    end else if (!irq_wake && !pd_sync[1]) begin
                        state <= pdw_pkg::PDW_WAKE;
                    end
                end
                pdw_pkg::PDW_WAKE: begin
                    state <= pdw_pkg::PDW_RUN;
                end
                default: begin
                    state <= pdw_pkg::PDW_INIT;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // registers on the external data bus
    // -----------------------------------------------------------------
    logic [7:0] misc_clock_config;
    logic crystal_block_bit_blocked;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_clock_config <= `PDW_MISC_CLK_RST;
            memory_timing_ctrl <= `PDW_MEM_TIMING_RST;
            crystal_block_bit_blocked <= 1'b0;
        end else if (pin_rst | por_rst) begin
            misc_clock_config <= `PDW_MISC_CLK_RST;
            memory_timing_ctrl <= `PDW_MEM_TIMING_RST;
            crystal_block_bit_blocked <= 1'b0;
        end else begin
            if (state_is_run && pd_request) begin
                crystal_block_bit_blocked <= pd_select[4];
            end
            // blocked crystal: come back on the ring oscillator
            if (state != pdw_pkg::PDW_RUN && state != pdw_pkg::PDW_INIT && crystal_block_bit_blocked &&
                (app_rst || state == pdw_pkg::PDW_WAKE)) begin
                misc_clock_config[`PDW_CLKSEL_BIT] <= 1'b0;
            end else if (xwr && xaddr == `PDW_ADDR_MISC_CLK) begin
                misc_clock_config <= xwdata;
            end
            if (xwr && xaddr == `PDW_ADDR_MEM_TIMING) begin
                memory_timing_ctrl <= xwdata;
            end
        end
    end
    // read mux, unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xrdata <= 8'h00;
        end else if (xrd && xaddr == `PDW_ADDR_MISC_CLK) begin
            xrdata <= misc_clock_config;
        end else if (xrd && xaddr == `PDW_ADDR_MEM_TIMING) begin
            xrdata <= memory_timing_ctrl;
        end else begin
            xrdata <= 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            powerdown_flag <= 1'b0;
            clock_gate_en <= 1'b1;
            osc_enable <= 1'b1;
            crystal_select <= 1'b0;
            cpu_reset <= 1'b1;
            cpu_resume <= 1'b0;
            cpu_start_addr <= `PDW_RESUME_ADDR;
            irq_handler_req <= 1'b0;
            init_busy <= 1'b1;
        end else begin
            powerdown_flag <= pd_latch;
            // clocks stay gated until the synchronised flag drops
            clock_gate_en <= !(state == pdw_pkg::PDW_DOWN ||
                               (state == pdw_pkg::PDW_OSC && pd_sync[1]));
            osc_enable <= (state != pdw_pkg::PDW_DOWN);
            crystal_select <= misc_clock_config[`PDW_CLKSEL_BIT];
            cpu_reset <= (state == pdw_pkg::PDW_INIT) | pin_rst | por_rst;
            cpu_resume <= (state == pdw_pkg::PDW_DOWN || state == pdw_pkg::PDW_OSC) && app_rst;
            cpu_start_addr <= `PDW_RESUME_ADDR;
            irq_handler_req <= (state == pdw_pkg::PDW_WAKE);
            init_busy <= (state == pdw_pkg::PDW_INIT);
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_down_app;
        state == pdw_pkg::PDW_DOWN && app_rst && !pin_rst && !por_rst;
    endsequence
    a_pin_reset_init: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin_rst |=> state == pdw_pkg::PDW_INIT)
        else $error("pin reset did not start init");
    a_wdt_no_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pdw_pkg::PDW_DOWN && wdt_rst && !pd_exit && !irq_wake)
        |=> state == pdw_pkg::PDW_DOWN)
        else $error("watchdog ended power-down");
    a_app_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_down_app |=> state == pdw_pkg::PDW_RUN ##0 cpu_resume)
        else $error("app reset did not resume");
    a_irq_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pdw_pkg::PDW_DOWN && irq_wake && !pd_exit) |=> ##1 osc_enable)
        else $error("oscillator not restarted");
    a_osc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pdw_pkg::PDW_OSC && irq_wake && !pd_exit)
        |=> state == pdw_pkg::PDW_OSC)
        else $error("exit before irq release");
    a_wake_handler: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == pdw_pkg::PDW_WAKE |=> irq_handler_req && state == pdw_pkg::PDW_RUN)
        else $error("handler not requested");
    a_no_ungated_early: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == pdw_pkg::PDW_OSC && pd_sync[1]) |=> !clock_gate_en)
        else $error("clocks released before sync");
    a_gate_in_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state == pdw_pkg::PDW_DOWN) |=> !clock_gate_en && !osc_enable)
        else $error("clocks not stopped in power-down");
    a_clksel_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (xwr && xaddr == `PDW_ADDR_MISC_CLK && !pd_exit && state == pdw_pkg::PDW_RUN)
        |=> ##1 crystal_select == $past(xwdata[0], 2))
        else $error("clock select not applied");
    a_timing_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (xwr && xaddr == `PDW_ADDR_MEM_TIMING && !pin_rst && !por_rst)
        |=> memory_timing_ctrl == $past(xwdata))
        else $error("timing register not written");

    // -----------------------------------------------------------------
    // wake path assertions
    // -----------------------------------------------------------------
    // these follow the four ways out of power-down (pin, supply, app, irq) one step at a time
    // a reset-type exit always wins over an irq wake in the same cycle,
    // so the irq wake and hold properties (a_irq_osc, a_osc_hold) exclude pd_exit in their antecedent
    // the watchdog is synchronised only so the assertions can watch it;
    // no logic acts on it, which is what keeps it from ending power-down
    // the supply-fail reset is treated exactly like the pin reset: the
    // whole sequencer restarts init and the registers return to reset
    // limitation: the oscillator settle time is the waker's job; the
    // controller only waits for the irq release, so a waker that lets go
    // too early restarts the processor on an unsettled clock
    // trade-off: the async flag clear uses the raw sidebands so the latch
    // can drop with every clock stopped, at the price of a combinational
    // reset path that must be kept glitch-free in layout
    // the clocked copy of that flag passes two flops before it may open
    // the clock gate, so the gate only moves on a stable value
    // the crystal fallback to the ring oscillator is applied on the app
    // reset wake and on the last cycle of the irq wake, and it takes
    // priority over a bus write to the clock register in that cycle
    sequence s_down_quiet;
        state == pdw_pkg::PDW_DOWN && !irq_wake && !pd_exit;
    endsequence
    sequence s_down_app_blocked;
        state == pdw_pkg::PDW_DOWN && app_rst && !pin_rst && !por_rst && crystal_block_bit_blocked;
    endsequence
    // supply fail restarts init like the pin does
    a_supply_init: assert property (@(posedge sys_clk) disable iff (!rst_n)
        por_rst |=> state == pdw_pkg::PDW_INIT)
        else $error("supply reset did not start init");
    // nothing but an enabled level irq or a pin, app or supply reset leaves power-down
    a_irq_qualify: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_down_quiet |=> state == pdw_pkg::PDW_DOWN)
        else $error("power-down left without a wake");
    // once the oscillator is back the flag is already clear
    a_flag_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == pdw_pkg::PDW_OSC |-> !pd_latch)
        else $error("flag still set while waking");
    // app wake with a blocked crystal lands on the ring oscillator
    a_app_ring: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_down_app_blocked |=> ##1 !crystal_select)
        else $error("crystal still selected after app wake");
    // init is reported while it runs
    a_init_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == pdw_pkg::PDW_INIT |=> init_busy)
        else $error("init not reported busy");
    // the processor is held in reset by the pin
    a_pin_cpu_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin_rst |=> cpu_reset)
        else $error("pin reset did not reset the processor");
    // resume always starts at the fixed address
    a_resume_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_resume |-> cpu_start_addr == `PDW_RESUME_ADDR)
        else $error("resume address wrong");
    // in normal run the oscillator runs
    a_osc_running: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state == pdw_pkg::PDW_RUN |=> osc_enable)
        else $error("oscillator stopped while running");
endmodule
`default_nettype wire

/* include/pdw_params.svh */
// constants for the power-down wake controller
// Notes on behaviour
// - clock select bit zero ring, one crystal
// - clock config register answers at FE81h
// - memory timing register answers at FE33h
// - only pin reset, app reset, irq wake (code: a supply-fail reset also ends power-down)
// - low reset pin ends power-down, restarts clocks
// - pin reset resets all, ring, full init
// - watchdog reset cannot end power-down
// - supply-fail reset still works in power-down
// - app reset resumes at 0000h, no init
// - app wake falls back to ring oscillator (code: only when pd_select[4] blocked the crystal at power-down entry)
// - irq wakes only enabled, global, level mode
// - enabled irq restarts the oscillator at once
// - irq exit completes on release, handler runs
// - handler returns after power-down instruction
// - irq clears power-down flag asynchronously
`ifndef PDW_PARAMS_SVH
`define PDW_PARAMS_SVH
`define PDW_ADDR_MEM_TIMING 16'hFE33
`define PDW_ADDR_MISC_CLK 16'hFE81
`define PDW_CLKSEL_BIT 0
`define PDW_MEM_TIMING_RST 8'h00
`define PDW_MISC_CLK_RST 8'h00
`define PDW_RESUME_ADDR 16'h0000
`define PDW_INIT_CYCLES 16
`endif

/* include/pdw_pkg.sv */
// types for the power-down wake controller
package pdw_pkg;
    typedef enum logic [4:0] {
        PDW_INIT = 5'b00001,
        PDW_RUN = 5'b00010,
        PDW_DOWN = 5'b00100,
        PDW_OSC = 5'b01000,
        PDW_WAKE = 5'b10000
    } pdw_state_t;
endpackage

/* verif/pdw_sideband_model.sv */
// sideband partner model standing in for user logic in the configurable array
`timescale 1ns/10ps
`default_nettype none
module pdw_sideband_model (
    // clock
    input wire logic sys_clk,
    // sidebands toward the controller, active high levels
    output logic app_reset_sideband,
    output logic ext_irq_sideband_a,
    output logic ext_irq_sideband_b
);
    // idle: all sidebands released
    initial begin
        app_reset_sideband = 1'b0;
        ext_irq_sideband_a = 1'b0;
        ext_irq_sideband_b = 1'b0;
    end
    // application reset held for n cycles
    task automatic app_pulse(input int n);
        @(posedge sys_clk);
        app_reset_sideband <= 1'b1;
        repeat (n) @(posedge sys_clk);
        app_reset_sideband <= 1'b0;
    endtask
    // irq hold is never shorter than two cycles, longer holds let the oscillator settle
    task automatic irq_pulse(input logic sel_b, input int n);
        int hold;
        hold = (n < 2) ? 2 : n;
        @(posedge sys_clk);
        ext_irq_sideband_a <= ~sel_b;
        ext_irq_sideband_b <= sel_b;
        repeat (hold) @(posedge sys_clk);
        ext_irq_sideband_a <= 1'b0;
        ext_irq_sideband_b <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the power-down wake controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ----------------------------------------
    // signals and counters
    // ----------------------------------------
    logic sys_clk, rst_n, xwr, xrd, pd_request, ie_global, ie_a, ie_b, level_a, level_b;
    logic [15:0] xaddr, cpu_start_addr;
    logic [7:0] xwdata, xrdata, pd_select, memory_timing_ctrl, d;
    logic ext_reset_pin_n, app_reset_sideband, ext_irq_sideband_a, ext_irq_sideband_b;
    logic supply_fail, watchdog_reset, powerdown_flag, clock_gate_en, osc_enable;
    logic crystal_select, cpu_reset, cpu_resume, irq_handler_req, init_busy;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_resume = 0; // resume pulses seen so far
    int n_handler = 0; // handler request pulses seen so far
    // short init keeps the run brief
    pdw_ctrl #(.INIT_CYCLES(4)) i_dut (.sys_clk, .rst_n, .xaddr, .xwr, .xrd, .xwdata,
        .xrdata, .pd_request, .pd_select, .ie_global, .ie_a, .ie_b, .level_a, .level_b,
        .ext_reset_pin_n, .app_reset_sideband, .ext_irq_sideband_a, .ext_irq_sideband_b,
        .supply_fail, .watchdog_reset, .powerdown_flag, .clock_gate_en, .osc_enable,
        .crystal_select, .memory_timing_ctrl, .cpu_reset, .cpu_resume, .cpu_start_addr,
        .irq_handler_req, .init_busy);
    pdw_sideband_model m (.sys_clk, .app_reset_sideband, .ext_irq_sideband_a,
        .ext_irq_sideband_b);
    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // one-cycle pulses are counted so no scenario can miss them
    always @(posedge sys_clk) begin
        if (cpu_resume === 1'b1) n_resume++;
        if (irq_handler_req === 1'b1) n_handler++;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        xaddr <= a;
        xwdata <= v;
        xwr <= 1'b1;
        @(posedge sys_clk);
        xwr <= 1'b0;
    endtask
    // read data stands in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        xaddr <= a;
        xrd <= 1'b1;
        @(posedge sys_clk);
        xrd <= 1'b0;
        #1 v = xrdata;
    endtask
    task automatic wait_init;
        for (int i = 0; i < 40 && init_busy !== 1'b0; i++) tick(1);
    endtask
    task automatic go_down(input logic [7:0] sel);
        @(posedge sys_clk);
        pd_select <= sel;
        pd_request <= 1'b1;
        @(posedge sys_clk);
        pd_request <= 1'b0;
        tick(2);
        chk(16'(powerdown_flag), 16'h0001);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(16'hFE33, d);
        chk({8'h00, d}, 16'h0000);
        rd(16'hFE81, d);
        chk({8'h00, d}, 16'h0000);
        wr(16'hFE33, 8'hA5);
        rd(16'hFE33, d);
        chk({8'h00, d}, 16'h00A5);
        chk({8'h00, memory_timing_ctrl}, 16'h00A5);
        wr(16'hFE81, 8'h01);
        tick(2);
        chk(16'(crystal_select), 16'h0001);
        wr(16'hFE82, 8'hFF);
        rd(16'hFE82, d);
        chk({8'h00, d}, 16'h0000);
    endtask
    // slow crystal: conservative timing, irq wake, crystal back, timing restored
    task automatic t_irq;
        wr(16'hFE33, 8'h07);
        ie_global <= 1'b1;
        ie_a <= 1'b1;
        level_a <= 1'b1;
        go_down(8'h10);
        @(posedge sys_clk);
        watchdog_reset <= 1'b1;
        tick(4);
        watchdog_reset <= 1'b0;
        tick(3);
        chk(16'(powerdown_flag), 16'h0001);
        chk(16'(init_busy), 16'h0000);
        fork
            m.irq_pulse(1'b0, 12);
        join_none
        tick(7);
        chk(16'(osc_enable), 16'h0001);
        chk(16'(powerdown_flag), 16'h0000);
        chk(16'(n_handler), 16'h0000);
        for (int i = 0; i < 40 && n_handler == 0; i++) tick(1);
        tick(2);
        chk(16'(n_handler), 16'h0001);
        chk(16'(crystal_select), 16'h0000);
        wr(16'hFE81, 8'h01);
        wr(16'hFE33, 8'h03);
        chk(16'(crystal_select), 16'h0001);
    endtask
    // unqualified irqs leave the device down, then the app reset wakes it
    task automatic t_app;
        ie_global <= 1'b0;
        go_down(8'h10);
        m.irq_pulse(1'b0, 8);
        tick(6);
        chk(16'(powerdown_flag), 16'h0001);
        ie_global <= 1'b1;
        ie_b <= 1'b1;
        m.irq_pulse(1'b1, 8);
        tick(6);
        chk(16'(powerdown_flag), 16'h0001);
        ie_b <= 1'b0;
        m.app_pulse(4);
        for (int i = 0; i < 40 && n_resume == 0; i++) tick(1);
        tick(2);
        chk(16'(n_resume), 16'h0001);
        chk(cpu_start_addr, 16'h0000);
        chk(16'(init_busy), 16'h0000);
        chk(16'(powerdown_flag), 16'h0000);
        chk(16'(crystal_select), 16'h0000);
        wr(16'hFE33, 8'h02);
        wr(16'hFE81, 8'h01);
    endtask
    // pin reset from power-down runs full init on the ring oscillator
    task automatic t_pin;
        go_down(8'h00);
        @(posedge sys_clk);
        ext_reset_pin_n <= 1'b0;
        tick(5);
        chk(16'(cpu_reset), 16'h0001);
        chk(16'(powerdown_flag), 16'h0000);
        chk(16'(clock_gate_en), 16'h0001);
        ext_reset_pin_n <= 1'b1;
        wait_init();
        chk(16'(crystal_select), 16'h0000);
        chk(16'(cpu_reset), 16'h0000);
    endtask
    task automatic t_supply;
        go_down(8'h00);
        @(posedge sys_clk);
        supply_fail <= 1'b1;
        tick(5);
        chk(16'(init_busy), 16'h0001);
        supply_fail <= 1'b0;
        wait_init();
        chk(16'(powerdown_flag), 16'h0000);
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {rst_n, xwr, xrd, pd_request, ie_global, ie_a, ie_b, level_a, level_b} = '0;
        {xaddr, xwdata, pd_select, supply_fail, watchdog_reset} = '0;
        ext_reset_pin_n = 1'b1;
        tick(3);
        rst_n <= 1'b1;
        wait_init();
        t_regs();
        t_irq();
        t_app();
        t_pin();
        t_supply();
        summarize();
    end
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
